// *** logic/acr_adc_ctrl.sv ***
// Converter control: clock selection, result formatting, byte interlock, auto-scan.
// Assumes an APB master and an analog core that pulses conv_done with conv_result.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module acr_adc_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic oscillator_clock,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  output logic conv_clk_en,
  output logic conv_start,
  output logic [4:0] conv_channel
);
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] prescale_select;
    logic clock_source_select;
    logic [1:0] mode;
    logic conversion_irq_enable;
    logic continuous_enable;
    logic [4:0] chan;
    logic scan_enable;
    logic [1:0] scan_count;
    logic conversion_done_flag;
    logic locked;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic [2:0][7:0] scan_result;
    acr_pkg::acr_conv_t conv;
    logic [1:0] scan_idx;
    logic conv_start;
    logic [4:0] conv_channel;
  } acr_state_t;

  acr_state_t s_reg;
  acr_state_t s_next;
  logic access;
  logic finish;
  logic mapped;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic wr_status;
  logic wr_clock;
  logic wr_scan;
  logic rd_high;
  logic rd_low_any;
  logic completes;
  logic tick_sel;

  // Bus clock source ticks every cycle; the oscillator arrives as an enable
  assign tick_sel = (s_reg.clock_source_select == acr_pkg::SOURCE_BUS) ? 1'b1 : oscillator_clock;

  acr_prescaler u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .tick_in(tick_sel),
    .prescale_select(s_reg.prescale_select),
    .div_tick(conv_clk_en)
  );

  assign access = psel && penable;
  assign finish = access && s_reg.pready;
  assign idx = paddr[9:2];
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
    (idx >= acr_pkg::IDX_STATUS) && (idx <= acr_pkg::IDX_SCAN_CTRL);
  assign wr_status = finish && pwrite && mapped && idx == acr_pkg::IDX_STATUS;
  assign wr_clock = finish && pwrite && mapped && idx == acr_pkg::IDX_CLOCK;
  assign wr_scan = finish && pwrite && mapped && idx == acr_pkg::IDX_SCAN_CTRL;
  assign rd_high = finish && !pwrite && mapped && idx == acr_pkg::IDX_RES_HIGH;
  assign rd_low_any = finish && !pwrite && mapped &&
    (idx >= acr_pkg::IDX_RES_LOW) && (idx <= acr_pkg::IDX_SCAN_THREE);
  assign completes = conv_done && (s_reg.conv == acr_pkg::CONV_BUSY);

  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      acr_pkg::IDX_STATUS: begin
        // Flag is hidden while interrupts are enabled
        rd_byte = {s_reg.conversion_done_flag && !s_reg.conversion_irq_enable,
          s_reg.conversion_irq_enable, s_reg.continuous_enable, s_reg.chan};
      end
      acr_pkg::IDX_CLOCK: begin
        rd_byte = {s_reg.prescale_select, s_reg.clock_source_select, s_reg.mode, 2'h0};
      end
      acr_pkg::IDX_RES_HIGH: begin
        // Truncated mode hides what a ten-bit mode left in the high byte
        if (s_reg.mode == acr_pkg::MODE_TRUNC) begin
          rd_byte = 8'h00;
        end else begin
          rd_byte = s_reg.result_high_byte;
        end
      end
      acr_pkg::IDX_RES_LOW: rd_byte = s_reg.result_low_byte;
      acr_pkg::IDX_SCAN_ONE: rd_byte = s_reg.scan_result[0];
      acr_pkg::IDX_SCAN_TWO: rd_byte = s_reg.scan_result[1];
      acr_pkg::IDX_SCAN_THREE: rd_byte = s_reg.scan_result[2];
      acr_pkg::IDX_SCAN_CTRL: rd_byte = {5'h00, s_reg.scan_enable, s_reg.scan_count};
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.conv_start = 1'b0;
    // One wait state: data and error are registered in the first access cycle
    s_next.pready = access && !s_reg.pready;
    if (access && !s_reg.pready) begin
      s_next.prdata = {24'h000000, rd_byte};
      s_next.pslverr = !mapped;
    end

    if (wr_status) begin
      s_next.conversion_irq_enable = pwdata[acr_pkg::STAT_IRQ_EN_BIT];
      s_next.continuous_enable = pwdata[acr_pkg::STAT_CONT_BIT];
      s_next.chan = pwdata[4:0];
    end
    if (wr_clock) begin
      s_next.prescale_select = pwdata[acr_pkg::CLK_PRESCALE_LSB +: 3];
      s_next.clock_source_select = pwdata[acr_pkg::CLK_SOURCE_BIT];
      s_next.mode = pwdata[acr_pkg::CLK_MODE_LSB +: 2];
    end
    if (wr_scan) begin
      s_next.scan_enable = pwdata[acr_pkg::SCAN_EN_BIT];
      s_next.scan_count = pwdata[acr_pkg::SCAN_COUNT_LSB +: 2];
    end

    // Interlock: releasing writes and the low read win over a high read; truncated mode always clears it
    if (wr_status || wr_clock || (rd_low_any && idx == acr_pkg::IDX_RES_LOW)) begin
      s_next.locked = 1'b0;
    end else if (rd_high && s_reg.mode != acr_pkg::MODE_TRUNC) begin
      s_next.locked = 1'b1;
    end
    if (s_reg.mode == acr_pkg::MODE_TRUNC) begin
      s_next.locked = 1'b0;
    end

    if ((wr_status || wr_clock || rd_low_any) && !s_reg.conversion_irq_enable) begin
      s_next.conversion_done_flag = 1'b0;
    end
    // A completion in the clearing cycle still sets the flag
    if (completes) begin
      s_next.conversion_done_flag = 1'b1;
    end

    if (completes) begin
      s_next.conv = acr_pkg::CONV_IDLE;
      if (s_reg.scan_enable && s_reg.scan_idx != 2'h0) begin
        s_next.scan_result[s_reg.scan_idx - 2'h1] = conv_result[9:2];
      end else if (s_reg.mode == acr_pkg::MODE_TRUNC) begin
        s_next.result_high_byte = 8'h00;
        s_next.result_low_byte = conv_result[9:2];
      end else if (!s_next.locked) begin
        // Results landing while locked are dropped, keeping the byte pair coherent
        unique case (s_reg.mode)
          acr_pkg::MODE_RIGHT: begin
            s_next.result_high_byte = {6'h00, conv_result[9:8]};
            s_next.result_low_byte = conv_result[7:0];
          end
          acr_pkg::MODE_LEFT: begin
            s_next.result_high_byte = conv_result[9:2];
            s_next.result_low_byte = {conv_result[1:0], 6'h00};
          end
          acr_pkg::MODE_SIGN: begin
            s_next.result_high_byte = {!conv_result[9], conv_result[8:2]};
            s_next.result_low_byte = {conv_result[1:0], 6'h00};
          end
          acr_pkg::MODE_TRUNC: begin
            s_next.result_high_byte = 8'h00;
            s_next.result_low_byte = conv_result[9:2];
          end
        endcase
      end
      if (s_reg.scan_enable) begin
        // Ascending order, wrapping after the last selected channel
        s_next.scan_idx = (s_reg.scan_idx >= s_reg.scan_count) ? 2'h0 : s_reg.scan_idx + 2'h1;
        s_next.conv_start = 1'b1;
        s_next.conv_channel = {3'h0, s_next.scan_idx};
        s_next.conv = acr_pkg::CONV_BUSY;
      end else if (s_reg.continuous_enable && s_reg.chan != acr_pkg::CHAN_OFF) begin
        s_next.conv_start = 1'b1;
        s_next.conv_channel = s_reg.chan;
        s_next.conv = acr_pkg::CONV_BUSY;
      end
    end

    // Software starts take priority over an automatic restart
    if (wr_scan && pwdata[acr_pkg::SCAN_EN_BIT]) begin
      s_next.scan_idx = 2'h0;
      s_next.conv_start = 1'b1;
      s_next.conv_channel = 5'h00;
      s_next.conv = acr_pkg::CONV_BUSY;
    end else if (wr_status && !s_reg.scan_enable) begin
      if (pwdata[4:0] == acr_pkg::CHAN_OFF) begin
        s_next.conv_start = 1'b0;
        s_next.conv = acr_pkg::CONV_IDLE;
      end else begin
        s_next.conv_start = 1'b1;
        s_next.conv_channel = pwdata[4:0];
        s_next.conv = acr_pkg::CONV_BUSY;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.prescale_select <= acr_pkg::PRESCALE_RESET;
      s_reg.clock_source_select <= acr_pkg::SOURCE_RESET;
      s_reg.mode <= acr_pkg::MODE_RESET;
      s_reg.chan <= acr_pkg::CHAN_OFF;
      s_reg.scan_count <= acr_pkg::SCAN_COUNT_RESET;
      s_reg.scan_enable <= 1'b0;
      s_reg.conv <= acr_pkg::CONV_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready = s_reg.pready;
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.pslverr;
  assign conv_start = s_reg.conv_start;
  assign conv_channel = s_reg.conv_channel;

  a_trunc_layout: assert property (@(posedge clk) disable iff (!resetn)
    (completes && !s_reg.scan_enable && s_reg.mode == acr_pkg::MODE_TRUNC) |=>
    (s_reg.result_high_byte == 8'h00 && s_reg.result_low_byte == $past(conv_result[9:2])))
    else $error("truncated result misplaced");
  a_right_layout: assert property (@(posedge clk) disable iff (!resetn)
    (completes && !s_reg.scan_enable && s_reg.mode == acr_pkg::MODE_RIGHT && !s_next.locked)
    |=> (s_reg.result_high_byte == {6'h00, $past(conv_result[9:8])} &&
    s_reg.result_low_byte == $past(conv_result[7:0])))
    else $error("right justified result misplaced");
  a_left_layout: assert property (@(posedge clk) disable iff (!resetn)
    (completes && !s_reg.scan_enable && s_reg.mode == acr_pkg::MODE_LEFT && !s_next.locked)
    |=> (s_reg.result_high_byte == $past(conv_result[9:2]) &&
    s_reg.result_low_byte == {$past(conv_result[1:0]), 6'h00}))
    else $error("left justified result misplaced");
  a_sign_layout: assert property (@(posedge clk) disable iff (!resetn)
    (completes && !s_reg.scan_enable && s_reg.mode == acr_pkg::MODE_SIGN && !s_next.locked)
    |=> (s_reg.result_high_byte[7] == !$past(conv_result[9])))
    else $error("sign bit not inverted");
  a_lock_holds: assert property (@(posedge clk) disable iff (!resetn)
    (s_reg.locked && s_next.locked) |=> $stable(s_reg.result_low_byte))
    else $error("low byte changed while locked");
  a_lock_release: assert property (@(posedge clk) disable iff (!resetn)
    (wr_status || wr_clock) |=> !s_reg.locked)
    else $error("lock survived a control write");
  a_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
    (rd_low_any && !completes && !s_reg.conversion_irq_enable) |=> !s_reg.conversion_done_flag)
    else $error("done flag not cleared by low read");
  a_scan_store: assert property (@(posedge clk) disable iff (!resetn)
    (completes && s_reg.scan_enable && s_reg.scan_idx == 2'h2) |=>
    (s_reg.scan_result[1] == $past(conv_result[9:2])))
    else $error("scan result two not stored");
  a_scan_wrap: assert property (@(posedge clk) disable iff (!resetn)
    (completes && s_reg.scan_enable && s_reg.scan_idx >= s_reg.scan_count && !wr_scan && !wr_status)
    |=> (s_reg.conv_start && s_reg.conv_channel == 5'h00))
    else $error("scan did not wrap to channel zero");
  a_scan_gate: assert property (@(posedge clk) disable iff (!resetn)
    (completes && !s_reg.scan_enable && !s_reg.continuous_enable && !wr_scan && !wr_status)
    |=> !s_reg.conv_start)
    else $error("conversion restarted without scan or continuous");

  // Interlock entry, and the mode that must never enter it
  a_lock_set: assert property (@(posedge clk) disable iff (!resetn)
    (rd_high && s_reg.mode != acr_pkg::MODE_TRUNC) |=> s_reg.locked)
    else $error("high byte read did not lock");
  a_trunc_unlocked: assert property (@(posedge clk) disable iff (!resetn)
    (s_reg.mode == acr_pkg::MODE_TRUNC) |=> !s_reg.locked)
    else $error("truncated mode holds a lock");
  a_trunc_high_zero: assert property (@(posedge clk) disable iff (!resetn)
    (access && !s_reg.pready && idx == acr_pkg::IDX_RES_HIGH &&
    s_reg.mode == acr_pkg::MODE_TRUNC) |=> (s_reg.prdata == 32'h00000000))
    else $error("high byte not zero in truncated mode");
  a_sign_low: assert property (@(posedge clk) disable iff (!resetn)
    (completes && !s_reg.scan_enable && s_reg.mode == acr_pkg::MODE_SIGN && !s_next.locked)
    |=> (s_reg.result_low_byte == {$past(conv_result[1:0]), 6'h00}))
    else $error("sign mode low byte misplaced");
  a_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    completes |=> s_reg.conversion_done_flag)
    else $error("done flag not set by a completion");

  // Control writes land as programmed
  a_clock_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_clock |=> (s_reg.prescale_select == $past(pwdata[acr_pkg::CLK_PRESCALE_LSB +: 3]) &&
    s_reg.clock_source_select == $past(pwdata[acr_pkg::CLK_SOURCE_BIT]) &&
    s_reg.mode == $past(pwdata[acr_pkg::CLK_MODE_LSB +: 2])))
    else $error("clock config write not taken");
  a_scan_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_scan |=> (s_reg.scan_enable == $past(pwdata[acr_pkg::SCAN_EN_BIT]) &&
    s_reg.scan_count == $past(pwdata[acr_pkg::SCAN_COUNT_LSB +: 2])))
    else $error("scan control write not taken");

  // Scan sequencing between the wrap points
  a_scan_step: assert property (@(posedge clk) disable iff (!resetn)
    (completes && s_reg.scan_enable && s_reg.scan_idx < s_reg.scan_count &&
    !wr_scan && !wr_status) |=>
    (s_reg.conv_start && s_reg.conv_channel[1:0] == $past(s_reg.scan_idx) + 2'h1))
    else $error("scan did not step to the next channel");
  a_scan_one: assert property (@(posedge clk) disable iff (!resetn)
    (completes && s_reg.scan_enable && s_reg.scan_idx == 2'h1) |=>
    (s_reg.scan_result[0] == $past(conv_result[9:2])))
    else $error("scan result one not stored");
  a_scan_three: assert property (@(posedge clk) disable iff (!resetn)
    (completes && s_reg.scan_enable && s_reg.scan_idx == 2'h3) |=>
    (s_reg.scan_result[2] == $past(conv_result[9:2])))
    else $error("scan result three not stored");
  a_scan_chan0: assert property (@(posedge clk) disable iff (!resetn)
    (completes && s_reg.scan_enable && s_reg.scan_idx == 2'h0 &&
    s_reg.mode == acr_pkg::MODE_TRUNC) |=> (s_reg.result_low_byte == $past(conv_result[9:2])))
    else $error("scan channel zero not truncated");
endmodule

// *** logic/acr_pkg.sv ***
// Constants and types shared by the converter control logic.
// Assumes a 32-bit APB bus and an external converter core that signals completion.
package acr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h57;
  localparam logic [7:0] IDX_CLOCK = 8'h58;
  localparam logic [7:0] IDX_RES_HIGH = 8'h59;
  localparam logic [7:0] IDX_RES_LOW = 8'h5A;
  localparam logic [7:0] IDX_SCAN_ONE = 8'h5B;
  localparam logic [7:0] IDX_SCAN_TWO = 8'h5C;
  localparam logic [7:0] IDX_SCAN_THREE = 8'h5D;
  localparam logic [7:0] IDX_SCAN_CTRL = 8'h5E;
  // Field positions
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_IRQ_EN_BIT = 6;
  localparam int STAT_CONT_BIT = 5;
  localparam int CLK_PRESCALE_LSB = 5;
  localparam int CLK_SOURCE_BIT = 4;
  localparam int CLK_MODE_LSB = 2;
  localparam int SCAN_EN_BIT = 2;
  localparam int SCAN_COUNT_LSB = 0;
  // Justification modes
  localparam logic [1:0] MODE_TRUNC = 2'h0;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_LEFT = 2'h2;
  localparam logic [1:0] MODE_SIGN = 2'h3;
  // Values after reset
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic SOURCE_RESET = 1'b0;
  localparam logic [1:0] MODE_RESET = MODE_RIGHT;
  localparam logic [4:0] CHAN_OFF = 5'h1F;
  localparam logic [1:0] SCAN_COUNT_RESET = 2'h0;
  localparam logic SOURCE_BUS = 1'b1;

  typedef enum logic [0:0] {CONV_IDLE, CONV_BUSY} acr_conv_t;
endpackage

// *** logic/acr_prescaler.sv ***
// Converter clock prescaler: divides the selected tick stream by 1, 2, 4, 8 or 16.
// Assumes tick_in is a one-cycle enable synchronous to clk.
`timescale 1ns/1ps
module acr_prescaler (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick_in,
  input wire logic [2:0] prescale_select,
  output logic div_tick
);
  typedef struct packed {
    logic [3:0] cnt;
    logic out;
  } acr_div_state_t;

  acr_div_state_t s_reg;
  acr_div_state_t s_next;
  logic [3:0] last;

  // Top bit set forces the largest ratio
  assign last = prescale_select[2] ? 4'hF : 4'((5'h01 << prescale_select[1:0]) - 5'h01);

  always_comb begin
    s_next = s_reg;
    s_next.out = 1'b0;
    if (tick_in) begin
      if (s_reg.cnt >= last) begin
        s_next.cnt = 4'h0;
        s_next.out = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign div_tick = s_reg.out;

  a_div_fire: assert property (@(posedge clk) disable iff (!resetn)
    (tick_in && s_reg.cnt == last) |=> div_tick)
    else $error("prescaler missed its terminal count");
  a_div_cause: assert property (@(posedge clk) disable iff (!resetn)
    div_tick |-> ($past(tick_in) && $past(s_reg.cnt) >= $past(last)))
    else $error("prescaler pulsed early");
endmodule

// *** bench/acr_adc_ctrl_test.sv ***
// Self-checking bench for the converter control block: registers, formatting, lock, scan.
// Assumes one APB wait state; the bench plays the analog core and the oscillator ticks.
`timescale 1ns/1ps
module acr_adc_ctrl_test;
  typedef struct {logic [1:0] mode; logic [9:0] res; logic [7:0] hi; logic [7:0] lo;} acr_row_t;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic e, oscillator_clock, conv_done, conv_clk_en, conv_start;
  logic [9:0] conv_result;
  logic [4:0] conv_channel;
  int n_fail, checked, cyc, n;
  acr_row_t rows [4] = '{
    '{acr_pkg::MODE_TRUNC, 10'h2B5, 8'h00, 8'hAD},
    '{acr_pkg::MODE_RIGHT, 10'h1C3, 8'h01, 8'hC3},
    '{acr_pkg::MODE_LEFT, 10'h2B5, 8'hAD, 8'h40},
    '{acr_pkg::MODE_SIGN, 10'h1C3, 8'hF0, 8'hC0}};

  acr_adc_ctrl dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .oscillator_clock(oscillator_clock), .conv_done(conv_done),
    .conv_result(conv_result), .conv_clk_en(conv_clk_en), .conv_start(conv_start),
    .conv_channel(conv_channel));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Oscillator enable ticks every second cycle, so an oscillator source halves the rate
  always @(posedge clk) oscillator_clock <= ~oscillator_clock;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer; starts with an idle edge so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    d = prdata;
    e = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("read data", {24'h0, exp}, d);
    chk("read error", 32'h0, {31'h0, e});
  endtask

  // Plays the core; ws=0 when a restart already happened and the core is busy
  task automatic convert(input logic [4:0] ch, input logic [9:0] r, input logic ws);
    int k;
    k = 0;
    if (ws) begin
      do begin
        @(posedge clk);
        k++;
      end while (conv_start !== 1'b1 && k < 50);
      chk("conv_start", 32'h1, {31'h0, conv_start});
      chk("conv_channel", {27'h0, ch}, {27'h0, conv_channel});
    end
    conv_done <= 1'b1;
    conv_result <= r;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask

  // Period divides 64, so a settled window always holds exactly 64/period pulses
  task automatic cnt_ticks(output int c);
    c = 0;
    repeat (20) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      c += int'(conv_clk_en);
    end
  endtask

  task automatic reset_check();
    for (int i = 0; i < 8; i++) begin
      rd(8'(8'h57 + i), (i == 0) ? 8'h1F : (i == 1) ? 8'h04 : 8'h00);
    end
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    conv_done = 1'b0;
    conv_result = '0;
    oscillator_clock = 1'b0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    reset_check();
    apb(1'b0, 8'h60, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    foreach (rows[i]) begin
      wr(8'h58, {3'h0, 1'b1, rows[i].mode, 2'h0});
      wr(8'h57, 8'h00);
      convert(5'h00, rows[i].res, 1'b1);
      rd(8'h57, 8'h80);
      rd(8'h59, rows[i].hi);
      rd(8'h5A, rows[i].lo);
      rd(8'h57, 8'h00);
    end
    // With interrupts enabled the done flag must read back as zero
    wr(8'h58, 8'h14);
    wr(8'h57, 8'h40);
    convert(5'h00, 10'h1C3, 1'b1);
    rd(8'h57, 8'h40);
    // Continuous conversion keeps the core busy so results land while the lock is held
    wr(8'h58, 8'h14);
    wr(8'h57, 8'h20);
    convert(5'h00, 10'h2B5, 1'b1);
    rd(8'h59, 8'h02);
    convert(5'h00, 10'h1C3, 1'b0);
    rd(8'h5A, 8'hB5);
    convert(5'h00, 10'h1C3, 1'b0);
    rd(8'h5A, 8'hC3);
    rd(8'h59, 8'h01);
    convert(5'h00, 10'h0FF, 1'b0);
    wr(8'h58, 8'h14);
    convert(5'h00, 10'h2B5, 1'b0);
    rd(8'h5A, 8'hB5);
    wr(8'h58, 8'h10);
    rd(8'h59, 8'h00);
    convert(5'h00, 10'h1C3, 1'b0);
    rd(8'h5A, 8'h70);
    wr(8'h57, 8'h1F);
    for (int p = 0; p < 8; p++) begin
      wr(8'h58, {p[2:0], 1'b1, 4'h4});
      cnt_ticks(n);
      chk("divided ticks", 32'(64 >> ((p > 4) ? 4 : p)), 32'(n));
    end
    wr(8'h58, 8'h24);
    cnt_ticks(n);
    chk("oscillator ticks", 32'd16, 32'(n));
    wr(8'h58, 8'h00);
    wr(8'h5E, 8'h06);
    convert(5'h00, 10'h004, 1'b1);
    convert(5'h01, 10'h3FC, 1'b1);
    convert(5'h02, 10'h155, 1'b1);
    convert(5'h00, 10'h2B5, 1'b1);
    wr(8'h5E, 8'h02);
    rd(8'h5A, 8'hAD);
    rd(8'h5B, 8'hFF);
    rd(8'h5C, 8'h55);
    rd(8'h5D, 8'h00);
    rd(8'h5E, 8'h02);
    // Second reset in mid-run must bring every register back
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    reset_check();
    test_done();
  end
endmodule
